// *** hw/adhs_seq.sv ***
// Notes on behaviour
// - enable set from stop enters trigger standby
// - trigger in standby converts selected input, sets status bit
// - each conversion end that passes the range check stores result and pulses end irq
// - select sequential restarts next conversion without trigger
// - trigger during conversion aborts, discards, restarts
// - select mode channel write during conversion converts new input
// - status bit written 1 during conversion restarts conversion
// - status bit cleared during conversion returns to standby, converter stopped
// - enable low ignores triggers, no conversion
// - one-shot end clears status bit and stops
// - scan converts four slots in order 0 to 3
// - scan stores result and raises irq per channel
// - scan sequential repeats pass without new trigger
// - scan trigger during conversion restarts at first slot
// - scan channel write during conversion restarts at new first slot
// - failed range check leaves result and irq untouched
// - irq only when result passes the selected range check
`default_nettype none
module adhs_seq #(
  parameter int unsigned RES_W    = adhs_pkg::RES_W,
  parameter int unsigned CH_W     = adhs_pkg::CH_W,
  parameter int unsigned CONV_CYC = adhs_pkg::CONV_CYC
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // control bits
  input  wire logic             converter_enable_bit,
  input  wire logic             scan_mode,
  input  wire logic             one_shot_mode,
  input  wire logic             status_wr,
  input  wire logic             status_wr_val,
  input  wire logic             channel_select_wr,
  input  wire logic [CH_W-1:0]  channel_select_val,
  input  wire logic             range_check_select,
  input  wire logic [RES_W-1:0] upper_limit_reg,
  input  wire logic [RES_W-1:0] lower_limit_reg,
  // hardware trigger pin
  input  wire logic             hw_trigger_pin,
  // analog front end
  output logic                  sample_req,
  output logic [CH_W-1:0]       sample_ch,
  input  wire logic             sample_done,
  input  wire logic [RES_W-1:0] sample_data,
  // status
  output logic                  conversion_status_bit,
  output logic                  converter_running,
  output logic [CH_W-1:0]       channel_select_reg,
  output logic [RES_W-1:0]      result_reg,
  output logic [7:0]            result_high_byte_reg,
  output logic                  conversion_end_irq,
  // result stream
  output logic                  res_valid,
  input  wire logic             res_ready,
  output logic [RES_W+CH_W-1:0] res_data
);
  typedef enum logic [1:0] {ST_STOP, ST_STANDBY, ST_CONV} adhs_state_t;
  localparam int unsigned CW = $clog2(CONV_CYC + 1);

  adhs_state_t     state_r;
  logic [CW-1:0]   cnt_r;
  logic [1:0]      slot_r;
  logic [CH_W-1:0] ch_r;
  logic            busy_r;
  logic            trig_rise;
  logic            conv_end;
  logic            in_range;
  logic            fifo_ready;
  logic [RES_W-1:0] cap_r;

  function automatic logic [CH_W-1:0] slot_ch(input logic [CH_W-1:0] base,
                                             input logic [1:0] slot,
                                             input logic scan);
    slot_ch = scan ? (base + CH_W'(slot)) : base;
  endfunction : slot_ch

  adhs_sync u_trig_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    (hw_trigger_pin),
    .level_out (),
    .rise_out  (trig_rise)
  );

  // a conversion holds off completing while the stream is full
  assign conv_end = busy_r && (cnt_r == '0) && fifo_ready;
  assign in_range = (range_check_select == adhs_pkg::RANGE_INSIDE) ?
                    (cap_r <= upper_limit_reg && cap_r >= lower_limit_reg) :
                    (cap_r > upper_limit_reg || cap_r < lower_limit_reg);

  logic restart;
  assign restart = busy_r && (trig_rise || channel_select_wr ||
                   (status_wr && status_wr_val));

  logic abort;
  logic store;
  // a clear or a dropped enable beats a coincident end or restart
  assign abort = (status_wr && !status_wr_val) || !converter_enable_bit;
  // a failed range check keeps the result and the stream untouched
  assign store = conv_end && !restart && !abort && in_range;

  // channel selection register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ch_r <= adhs_pkg::CH_RST;
    end else if (channel_select_wr) begin
      ch_r <= channel_select_val;
    end
  end

  // sequencer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= ST_STOP;
      busy_r  <= 1'b0;
      cnt_r   <= '0;
      slot_r  <= '0;
      conversion_status_bit <= 1'b0;
    end else begin
      unique case (state_r)
        ST_STOP: begin
          if (converter_enable_bit) begin
            state_r <= ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (!converter_enable_bit) begin
            state_r <= ST_STOP;
          end else if (trig_rise) begin
            state_r <= ST_CONV;
            busy_r  <= 1'b1;
            cnt_r   <= CW'(CONV_CYC);
            slot_r  <= '0;
            conversion_status_bit <= 1'b1;
          end
        end
        ST_CONV: begin
          if (abort) begin
            state_r <= converter_enable_bit ? ST_STANDBY : ST_STOP;
            busy_r  <= 1'b0;
            conversion_status_bit <= 1'b0;
          end else if (restart) begin
            cnt_r  <= CW'(CONV_CYC);
            slot_r <= '0;
          end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (conv_end) begin
            if (one_shot_mode && (!scan_mode || slot_r == 2'd3)) begin
              state_r <= ST_STANDBY;
              busy_r  <= 1'b0;
              conversion_status_bit <= 1'b0;
            end else begin
              cnt_r  <= CW'(CONV_CYC);
              slot_r <= scan_mode ? slot_r + 2'd1 : 2'd0;
            end
          end
        end
      endcase
    end
  end

  // front end request and capture
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sample_req <= 1'b0;
      sample_ch  <= adhs_pkg::CH_RST;
      cap_r      <= adhs_pkg::RESULT_RST;
    end else begin
      sample_req <= busy_r && !restart;
      sample_ch  <= slot_ch(ch_r, slot_r, scan_mode);
      if (sample_done) begin
        cap_r <= sample_data;
      end
    end
  end

  // result register and end pulse
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      result_reg         <= adhs_pkg::RESULT_RST;
      conversion_end_irq <= 1'b0;
    end else begin
      conversion_end_irq <= 1'b0;
      if (store) begin
        result_reg         <= cap_r;
        conversion_end_irq <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      converter_running    <= 1'b0;
      channel_select_reg   <= adhs_pkg::CH_RST;
      result_high_byte_reg <= 8'h00;
    end else begin
      // trigger standby leaves the converter itself stopped
      converter_running    <= busy_r;
      channel_select_reg   <= ch_r;
      result_high_byte_reg <= result_reg[RES_W-1 -: 8];
    end
  end

  adhs_fifo #(
    .WIDTH (RES_W + CH_W),
    .DEPTH (adhs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (store),
    .in_ready  (fifo_ready),
    .in_data   ({sample_ch, cap_r}),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  property p_irq_needs_range;
    @(posedge clk_sys) disable iff (reset)
    conversion_end_irq |-> $past(in_range) && $past(conv_end);
  endproperty
  a_irq_needs_range: assert property (p_irq_needs_range)
    else $error("end irq without passing range check");

  property p_result_hold;
    @(posedge clk_sys) disable iff (reset)
    !conversion_end_irq |-> $stable(result_reg);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without end irq");

  property p_enable_standby;
    @(posedge clk_sys) disable iff (reset)
    (state_r == ST_STOP && converter_enable_bit) |=> state_r == ST_STANDBY;
  endproperty
  a_enable_standby: assert property (p_enable_standby)
    else $error("enable did not reach standby");

  property p_trig_start;
    @(posedge clk_sys) disable iff (reset)
    (state_r == ST_STANDBY && converter_enable_bit && trig_rise)
      |=> busy_r && conversion_status_bit && slot_r == 2'd0;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger did not start conversion");

  property p_no_start_disabled;
    @(posedge clk_sys) disable iff (reset)
    (!busy_r && !converter_enable_bit) |=> !busy_r;
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled)
    else $error("conversion started while disabled");

  property p_restart;
    @(posedge clk_sys) disable iff (reset)
    (restart && converter_enable_bit && !(status_wr && !status_wr_val))
      |=> cnt_r == CW'(CONV_CYC) && slot_r == 2'd0 && !conversion_end_irq;
  endproperty
  a_restart: assert property (p_restart)
    else $error("abort did not restart at first slot");

  property p_clear_stop;
    @(posedge clk_sys) disable iff (reset)
    (busy_r && status_wr && !status_wr_val)
      |=> !busy_r && !conversion_status_bit ##1 !conversion_end_irq;
  endproperty
  a_clear_stop: assert property (p_clear_stop)
    else $error("status clear did not abort");

  property p_oneshot_end;
    @(posedge clk_sys) disable iff (reset)
    (conv_end && !restart && one_shot_mode && !scan_mode &&
     !status_wr && converter_enable_bit) |=> !conversion_status_bit;
  endproperty
  a_oneshot_end: assert property (p_oneshot_end)
    else $error("one-shot did not clear status");

  property p_seq_continue;
    @(posedge clk_sys) disable iff (reset)
    (conv_end && !restart && !one_shot_mode && !status_wr &&
     converter_enable_bit) |=> busy_r && cnt_r == CW'(CONV_CYC);
  endproperty
  a_seq_continue: assert property (p_seq_continue)
    else $error("sequential mode did not continue");

  property p_store_result;
    @(posedge clk_sys) disable iff (reset)
    store |=> conversion_end_irq && result_reg == $past(cap_r);
  endproperty
  a_store_result: assert property (p_store_result)
    else $error("passing end did not store result");

  property p_scan_step;
    @(posedge clk_sys) disable iff (reset)
    (conv_end && !restart && !abort && scan_mode &&
     !(one_shot_mode && slot_r == 2'd3))
      |=> slot_r == 2'($past(slot_r) + 2'd1);
  endproperty
  a_scan_step: assert property (p_scan_step)
    else $error("scan did not step to next slot");

  property p_scan_last;
    @(posedge clk_sys) disable iff (reset)
    (conv_end && !restart && !abort && scan_mode && one_shot_mode &&
     slot_r == 2'd3) |=> !busy_r && !conversion_status_bit;
  endproperty
  a_scan_last: assert property (p_scan_last)
    else $error("one-shot scan did not stop after last slot");

  property p_idle_write;
    @(posedge clk_sys) disable iff (reset)
    (!busy_r && channel_select_wr && !trig_rise)
      |=> !busy_r && ch_r == $past(channel_select_val);
  endproperty
  a_idle_write: assert property (p_idle_write)
    else $error("idle channel write misbehaved");
endmodule : adhs_seq
`default_nettype wire

// *** hw/adhs_pkg.sv ***
`default_nettype none
package adhs_pkg;
  localparam int unsigned RES_W      = 10;
  localparam int unsigned CH_W       = 5;
  localparam int unsigned SCAN_SLOTS = 4;
  localparam int unsigned FIFO_DEPTH = 16;
  // conversion time in ns, rounded up to whole clocks
  localparam int unsigned CONV_NS    = 100;
  localparam int unsigned CLK_NS     = 4;
  localparam int unsigned CONV_CYC   = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0]  RESULT_RST = 10'h000;
  localparam logic [4:0]  CH_RST     = 5'h00;
  // comparison select: 0 passes inside [lower, upper], 1 passes outside
  localparam logic        RANGE_INSIDE = 1'b0;
endpackage : adhs_pkg
`default_nettype wire

// *** hw/adhs_fifo.sv ***
`default_nettype none
module adhs_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [WIDTH-1:0] out_data_r;
  logic             out_valid_r;
  logic             push;
  logic             pop;
  logic             mem_any;
  logic             load;

  // the output stage counts toward the depth, so capacity stays DEPTH
  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  assign pop       = out_valid_r && out_ready;
  assign mem_any   = (count_r != (AW+1)'(out_valid_r));
  assign load      = mem_any && (!out_valid_r || out_ready);
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;

  // data words carry no reset: valid alone says whether they mean anything
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
    if (load) begin
      out_data_r <= mem[rd_ptr_r];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      count_r     <= '0;
      out_valid_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (load) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (!out_valid_r || out_ready) begin
        out_valid_r <= mem_any;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : adhs_fifo
`default_nettype wire

// *** hw/adhs_sync.sv ***
`default_nettype none
module adhs_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // a change counts once the second and third stages agree
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign level_out = level_r;
  assign rise_out  = (s2_r == s3_r) && s3_r && !level_r;
endmodule : adhs_sync
`default_nettype wire

// *** tb/adhs_afe_model.sv ***
`default_nettype none
module adhs_afe_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // sample handshake
  input  wire logic       sample_req,
  input  wire logic [4:0] sample_ch,
  input  wire logic       slow,
  output logic            sample_done,
  output logic [9:0]      sample_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) div_r <= 3'h0;
    else div_r <= div_r + 3'h1;
  end
  // a slow front end only reports every eighth clock
  assign sample_done = sample_req && (!slow || div_r == 3'h0);
  // idle bus shows a moving pattern, never the last sample
  assign sample_data = sample_req ? {sample_ch, sample_ch}
                                  : {div_r, 7'h55};
endmodule : adhs_afe_model
`default_nettype wire

// *** tb/adhs_seq_test.sv ***
`default_nettype none
module adhs_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, en, scan, one, st_wr, st_val, ch_wr, rck;
  logic trig, rdy, slow, sreq, sdone, cstat, run, irq, rv;
  logic [4:0] ch_val, sch, chreg, b, c, d;
  logic [9:0] ul, ll, sdat, res, r0, e;
  logic [7:0] resh;
  logic [14:0] rd;
  int num_errors, checks, seed, nirq, ndr, el, n0;
  logic [9:0] exp_q[$], sq[$];

  adhs_seq dut (.clk_sys(clk_sys), .reset(reset),
    .converter_enable_bit(en), .scan_mode(scan), .one_shot_mode(one),
    .status_wr(st_wr), .status_wr_val(st_val), .channel_select_wr(ch_wr),
    .channel_select_val(ch_val), .range_check_select(rck),
    .upper_limit_reg(ul), .lower_limit_reg(ll), .hw_trigger_pin(trig),
    .sample_req(sreq), .sample_ch(sch), .sample_done(sdone),
    .sample_data(sdat), .conversion_status_bit(cstat),
    .converter_running(run), .channel_select_reg(chreg),
    .result_reg(res), .result_high_byte_reg(resh),
    .conversion_end_irq(irq), .res_valid(rv), .res_ready(rdy),
    .res_data(rd));
  adhs_afe_model afe (.clk_sys(clk_sys), .reset(reset),
    .sample_req(sreq), .sample_ch(sch), .slow(slow),
    .sample_done(sdone), .sample_data(sdat));

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    en = 1'b0;
    scan = 1'b0;
    one = 1'b0;
    st_wr = 1'b0;
    st_val = 1'b0;
    ch_wr = 1'b0;
    rck = 1'b0;
    trig = 1'b0;
    rdy = 1'b1;
    slow = 1'b0;
    ch_val = 5'h00;
    ul = 10'h3ff;
    ll = 10'h000;
    num_errors = 0;
    checks = 0;
    seed = 81544;
    nirq = 0;
    ndr = 0;
  end
  always #2 clk_sys = ~clk_sys;

  function automatic logic [9:0] fv(logic [4:0] ch);
    return {ch, ch};
  endfunction : fv

  task automatic check(string what, logic [15:0] seen, logic [15:0] ex);
    checks++;
    if (seen !== ex) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, ex, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // results are judged when the end pulse shows them
  always @(negedge clk_sys) begin
    if (!reset && irq === 1'b1) begin
      nirq++;
      if (exp_q.size() == 0) begin
        check("irq", 1'b1, 1'b0);
      end else begin
        e = exp_q.pop_front();
        check("result", res, e);
        sq.push_back(e);
      end
    end
    // every stored result must leave the stream in order, tagged by channel
    if (!reset && rv === 1'b1 && rdy === 1'b1) begin
      ndr++;
      if (sq.size() == 0) begin
        check("stream_extra", 1'b1, 1'b0);
      end else begin
        e = sq.pop_front();
        check("stream", rd, {e[4:0], e});
      end
    end
  end

  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic pulse();
    @(posedge clk_sys);
    trig <= 1'b1;
    cyc(6);
    trig <= 1'b0;
  endtask : pulse
  task automatic wr_ch(logic [4:0] v);
    @(posedge clk_sys);
    ch_wr <= 1'b1;
    ch_val <= v;
    @(posedge clk_sys);
    ch_wr <= 1'b0;
  endtask : wr_ch
  task automatic wr_st(logic v);
    @(posedge clk_sys);
    st_wr <= 1'b1;
    st_val <= v;
    @(posedge clk_sys);
    st_wr <= 1'b0;
  endtask : wr_st
  task automatic wait_irq(int n);
    el = 0;
    while (nirq < n && el < 3000) begin
      @(posedge clk_sys);
      el++;
    end
    check("irq_count", nirq, n);
  endtask : wait_irq
  // enable is cycled so every scenario starts from the stop state
  task automatic set_mode(logic s, logic o);
    check("queue", exp_q.size(), 0);
    @(posedge clk_sys);
    en <= 1'b0;
    scan <= s;
    one <= o;
    cyc(3);
    en <= 1'b1;
    cyc(3);
    check("standby_idle", run, 1'b0);
    // external inputs only: no high-speed main mode is modelled here
    b = {1'b1, 4'($random(seed))};
    c = {1'b0, 4'($random(seed))};
    n0 = nirq;
  endtask : set_mode

  initial begin
    cyc(10);
    reset <= 1'b0;
    cyc(2);
    pulse();
    cyc(60);
    check("idle_status", cstat, 1'b0);
    set_mode(1'b0, 1'b1);
    wr_ch(b);
    cyc(40);
    check("chan_reg", chreg, b);
    check("no_start", sreq, 1'b0);
    for (int k = 0; k < 3; k++) begin
      set_mode(1'b0, 1'b1);
      wr_ch(b);
      exp_q.push_back(fv(k == 1 ? c : b));
      pulse();
      check("status_set", cstat, 1'b1);
      check("conv_run", run, 1'b1);
      cyc(4);
      case (k)
        0: pulse();
        1: wr_ch(c);
        default: wr_st(1'b1);
      endcase
      wait_irq(n0 + 1);
      check("restart", el >= 22, 1'b1);
      cyc(40);
    end
    set_mode(1'b0, 1'b0);
    pulse();
    cyc(4);
    wr_st(1'b0);
    cyc(60);
    check("clr_status", cstat, 1'b0);
    check("clr_conv", sreq, 1'b0);
    check("clr_run", run, 1'b0);
    set_mode(1'b0, 1'b0);
    slow <= 1'b1;
    wr_ch(b);
    repeat (3) exp_q.push_back(fv(b));
    pulse();
    wait_irq(n0 + 3);
    wr_st(1'b0);
    slow <= 1'b0;
    cyc(40);
    for (int k = 0; k < 3; k++) begin
      set_mode(1'b1, 1'b1);
      wr_ch(b);
      exp_q.push_back(fv(b));
      pulse();
      wait_irq(n0 + 1);
      cyc(10);
      if (k == 1) pulse();
      if (k == 2) wr_ch(c);
      d = (k == 2) ? c : b;
      for (int i = (k == 0); i < 4; i++) exp_q.push_back(fv(d + 5'(i)));
      wait_irq(n0 + (k == 0 ? 4 : 5));
      cyc(3);
      check("oneshot_status", cstat, 1'b0);
      check("oneshot_stop", run, 1'b0);
    end
    set_mode(1'b1, 1'b0);
    wr_ch(b);
    for (int i = 0; i < 6; i++) exp_q.push_back(fv(b + 5'(i % 4)));
    pulse();
    wait_irq(n0 + 6);
    wr_st(1'b0);
    cyc(40);
    set_mode(1'b0, 1'b1);
    wr_ch(b);
    ul <= fv(b) - 10'h001;
    r0 = res;
    pulse();
    cyc(60);
    check("kept_result", res, r0);
    check("kept_high", resh, r0[9:2]);
    for (int k = 0; k < 2; k++) begin
      set_mode(1'b0, 1'b1);
      wr_ch(b);
      // inside: the value sits on the upper bound; outside: just above it
      rck <= k[0];
      ul <= k[0] ? fv(b) - 10'h001 : fv(b);
      ll <= k[0] ? 10'h000 : fv(b) - 10'h001;
      exp_q.push_back(fv(b));
      pulse();
      wait_irq(n0 + 1);
    end
    set_mode(1'b0, 1'b0);
    rdy <= 1'b0;
    rck <= 1'b0;
    ul <= 10'h3ff;
    ll <= 10'h000;
    wr_ch(c);
    repeat (16) exp_q.push_back(fv(c));
    pulse();
    wait_irq(n0 + 16);
    cyc(60);
    check("fifo_stall", nirq, n0 + 16);
    wr_st(1'b0);
    n0 = ndr;
    rdy <= 1'b1;
    cyc(40);
    check("drained", ndr - n0, 16);
    check("empty", rv, 1'b0);
    check("stream_left", sq.size(), 0);
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
endmodule : adhs_seq_test
`default_nettype wire
